/* File: dv/phu_cache_model.sv */
// Behavioural translation and cache partner for the prefetch unit.
// Assumes one outstanding translation and one outstanding cache request.
`timescale 1ns/10ps
`default_nettype none
module phu_cache_model (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic [3:0]              xl_lat,
  input  wire logic [3:0]              stall,
  input  wire logic [3:0]              flags,
  input  wire logic [2:0]              cca,
  input  wire logic                    xlt_valid,
  input  wire logic [31:0]             xlt_vaddr,
  output var  logic                    xlt_rsp_valid,
  output var  phu_pkg::phu_xlate_t     xlt_rsp,
  input  wire logic                    cache_req_valid,
  input  wire phu_pkg::phu_cache_req_t cache_req,
  output var  logic                    cache_req_ready,
  output var  logic                    cache_done,
  output var  logic                    cache_error,
  output var  phu_pkg::phu_cache_req_t last_req,
  output var  logic [7:0]              n_req
);
  import phu_pkg::*;
  // Flags: fault, uncached, coherent, cache error
  initial begin
    xlt_rsp_valid = 1'h0;
    xlt_rsp = '0;
    cache_req_ready = 1'h0;
    cache_done = 1'h0;
    cache_error = 1'h0;
    last_req = '0;
    n_req = 8'h00;
  end
  // Sampled at the falling edge so a one-cycle pulse is never missed
  always @(negedge clk_sys) begin
    if (!sys_rst && xlt_valid) begin
      repeat (xl_lat) @(posedge clk_sys);
      @(posedge clk_sys);
      xlt_rsp_valid <= 1'h1;
      xlt_rsp <= '{fault: flags[3], uncached: flags[2], coherent: flags[1],
                   cache_coherency_attribute: cca, paddr: xlt_vaddr};
      @(posedge clk_sys);
      xlt_rsp_valid <= 1'h0;
      xlt_rsp <= ~xlt_rsp;
    end
  end
  always @(negedge clk_sys) begin
    if (!sys_rst && cache_req_valid) begin
      last_req <= cache_req;
      repeat (stall) @(posedge clk_sys);
      @(posedge clk_sys);
      cache_req_ready <= 1'h1;
      @(posedge clk_sys);
      cache_req_ready <= 1'h0;
      n_req <= n_req + 8'h01;
      @(posedge clk_sys);
      cache_done <= 1'h1;
      cache_error <= flags[0];
      @(posedge clk_sys);
      cache_done <= 1'h0;
      cache_error <= ~flags[0];
    end
  end
endmodule : phu_cache_model
`default_nettype wire

/* File: dv/phu_checker_properties.sv */
// Port checker for the data prefetch unit.
// Assumes it is bound to prefetch_hint_unit and shares its clock and reset.
`timescale 1ns/10ps
`default_nettype none
module phu_checker #(
  parameter bit REPORT_ERRORS = 1'h0
) (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire logic                  release_new,
  input wire logic                  pf_valid,
  input wire phu_pkg::phu_instr_t   pf_instr,
  input wire logic                  pf_ready,
  input wire logic                  pf_done,
  input wire logic                  pf_reserved_instr_exception,
  input wire logic                  pf_bus_error_exception,
  input wire logic                  general_register_write_en,
  input wire logic                  barrier_req,
  input wire logic                  barrier_ack,
  input wire logic                  xlt_valid,
  input wire logic [31:0]           xlt_vaddr,
  input wire logic                  xlt_rsp_valid,
  input wire phu_pkg::phu_xlate_t   xlt_rsp,
  input wire logic                  cache_req_valid,
  input wire phu_pkg::phu_cache_req_t cache_req,
  input wire logic                  cache_req_ready,
  input wire logic                  cache_done,
  input wire logic                  cache_error
);
  import phu_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_no_gpr; !general_register_write_en; endproperty
  a_no_gpr: assert property (p_no_gpr) else $error("register write seen");
  property p_ri_take; pf_valid && pf_ready && release_new && pf_instr.hint >= HINT_RSV_LO
    |=> pf_done && pf_reserved_instr_exception; endproperty
  a_ri_take: assert property (p_ri_take) else $error("reserved hint not trapped");
  property p_ri_only; pf_reserved_instr_exception |-> pf_done && $past(release_new); endproperty
  a_ri_only: assert property (p_ri_only) else $error("stray reserved trap");
  property p_addr_new; xlt_valid && $past(release_new) |-> xlt_vaddr == $past(pf_instr.base)
    + {{23{$past(pf_instr.offset[8])}}, $past(pf_instr.offset[8:0])}; endproperty
  a_addr_new: assert property (p_addr_new) else $error("short offset address");
  property p_addr_old; xlt_valid && !$past(release_new) |-> xlt_vaddr == $past(pf_instr.base)
    + {{16{$past(pf_instr.offset[15])}}, $past(pf_instr.offset)}; endproperty
  a_addr_old: assert property (p_addr_old) else $error("long offset address");
  property p_drop; xlt_rsp_valid && (xlt_rsp.fault || xlt_rsp.uncached)
    |=> pf_done && !cache_req_valid; endproperty
  a_drop: assert property (p_drop) else $error("dropped prefetch issued");
  property p_attr; xlt_rsp_valid && !xlt_rsp.fault && !xlt_rsp.uncached |=> cache_req_valid
    && cache_req.paddr == $past(xlt_rsp.paddr) && cache_req.coherent == $past(xlt_rsp.coherent)
    && cache_req.cache_coherency_attribute == $past(xlt_rsp.cache_coherency_attribute);
  endproperty
  a_attr: assert property (p_attr) else $error("request attributes differ");
  property p_hold; cache_req_valid && !cache_req_ready |=> cache_req_valid && $stable(cache_req);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped before ready");
  property p_locked; cache_req_valid |-> cache_req.spare_locked; endproperty
  a_locked: assert property (p_locked) else $error("locked lines not spared");
  property p_done; cache_done |=> pf_done ##1 pf_ready; endproperty
  a_done: assert property (p_done) else $error("completion order wrong");
  property p_barrier; barrier_ack |-> !pf_ready && !cache_req_valid && !xlt_valid ##1 !barrier_ack;
  endproperty
  a_barrier: assert property (p_barrier) else $error("barrier acked while busy");
  property p_err; pf_bus_error_exception |-> REPORT_ERRORS && pf_done; endproperty
  a_err: assert property (p_err) else $error("unexpected bus error report");
endmodule : phu_checker
`default_nettype wire

/* File: dv/test_prefetch_hint_unit.sv */
// Self-checking bench for prefetch_hint_unit.
// Assumes phu_pkg, the design, the model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_prefetch_hint_unit;
  import phu_pkg::*;
  logic           clk_sys = 1'h0;
  logic           sys_rst = 1'h1;
  logic           release_new = 1'h1;
  logic           pf_valid = 1'h0;
  phu_instr_t     pf_instr = '0;
  logic           barrier_req = 1'h0;
  logic [3:0]     xl_lat = 4'h0;
  logic [3:0]     stall = 4'h0;
  logic [3:0]     flags = 4'h0;
  logic [2:0]     cca = 3'h3;
  logic           pf_ready, pf_done, pf_reserved_instr_exception, pf_bus_error_exception;
  logic           general_register_write_en, barrier_ack, xlt_valid, xlt_rsp_valid;
  logic           cache_req_valid, cache_req_ready, cache_done, cache_error;
  logic [31:0]    xlt_vaddr;
  phu_xlate_t     xlt_rsp;
  phu_cache_req_t cache_req, last_req;
  logic [7:0]     n_req;
  int             n_fail = 0;
  int             cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  prefetch_hint_unit dut (.clk_sys, .sys_rst, .release_new, .pf_valid, .pf_instr, .pf_ready,
    .pf_done, .pf_reserved_instr_exception, .pf_bus_error_exception, .general_register_write_en,
    .barrier_req, .barrier_ack, .xlt_valid, .xlt_vaddr, .xlt_rsp_valid, .xlt_rsp,
    .cache_req_valid, .cache_req, .cache_req_ready, .cache_done, .cache_error);
  phu_cache_model far_end (.clk_sys, .sys_rst, .xl_lat, .stall, .flags, .cca, .xlt_valid,
    .xlt_vaddr, .xlt_rsp_valid, .xlt_rsp, .cache_req_valid, .cache_req, .cache_req_ready,
    .cache_done, .cache_error, .last_req, .n_req);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic pf_take(input logic [31:0] b, input logic [15:0] o, input logic [4:0] h);
    int k = 0;
    @(negedge clk_sys);
    pf_valid = 1'h1;
    pf_instr = '{base: b, offset: o, hint: h};
    while (pf_ready !== 1'h1) begin
      if (++k > 40) begin
        check("take wait", 32'h0, 32'h1);
        tally_and_finish();
      end
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
    pf_valid = 1'h0;
  endtask : pf_take
  task automatic pf_issue(input logic [31:0] b, input logic [15:0] o, input logic [4:0] h,
                          output logic ri_s, output logic be_s);
    int k = 0;
    pf_take(b, o, h);
    while (pf_done !== 1'h1) begin
      if (++k > 60) begin
        check("done wait", 32'h0, 32'h1);
        tally_and_finish();
      end
      @(negedge clk_sys);
    end
    ri_s = pf_reserved_instr_exception;
    be_s = pf_bus_error_exception;
  endtask : pf_issue
  // {trap, issued, op, level, streamed, retained}; hint 2 at L1 is supported under the new release only
  function automatic logic [7:0] expect_of(input logic rn, input logic [4:0] h);
    logic [1:0] g = h[4:3];
    logic [2:0] l = h[2:0];
    logic       ri = rn && (h >= 5'h18);
    logic       rq = !ri && (rn ? g != 2'h3 : g == 2'h0) && l != 3'h3
                     && (l != 3'h2 || (rn && g == 2'h0));
    return {ri, rq, (l == 3'h2) ? 2'h3 : (l[0] ? 2'h2 : 2'h1), g, l[2:1] == 2'h2, l[2:1] == 2'h3};
  endfunction : expect_of
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_hints;
    logic [7:0] e, n0;
    logic       ri_s, be_s;
    for (int r = 0; r < 2; r++) begin
      release_new = r[0];
      for (int h = 0; h < 32; h++) begin
        n0 = n_req;
        e = expect_of(r[0], h[4:0]);
        pf_issue(32'h0000_1000, 16'h0000, h[4:0], ri_s, be_s);
        check("trap", ri_s, e[7]);
        check("issued", n_req - n0, e[6]);
        if (e[6]) check("action", {last_req.op, last_req.level, last_req.streamed,
          last_req.retained}, e[5:0]);
      end
    end
  endtask : t_hints
  task automatic t_addr;
    logic [31:0] b [3] = '{32'h0000_8000, 32'h7fff_fff0, 32'h0000_0004};
    logic [15:0] o [3] = '{16'h01ff, 16'h0100, 16'hfffc};
    logic        ri_s, be_s;
    for (int r = 0; r < 2; r++) begin
      release_new = r[0];
      for (int i = 0; i < 3; i++) begin
        pf_issue(b[i], o[i], 5'h00, ri_s, be_s);
        check("paddr", last_req.paddr, r ? b[i] + {{23{o[i][8]}}, o[i][8:0]}
          : b[i] + {{16{o[i][15]}}, o[i]});
      end
    end
  endtask : t_addr
  task automatic t_attr;
    logic [7:0] n0;
    logic       ri_s, be_s;
    flags = 4'h3;
    cca = 3'h5;
    stall = 4'h3;
    xl_lat = 4'h4;
    pf_issue(32'h0000_2040, 16'h0000, 5'h01, ri_s, be_s);
    check("coherent", last_req.coherent, 1'h1);
    check("cca", last_req.cache_coherency_attribute, 3'h5);
    check("bus error", be_s, 1'h0);
    stall = 4'h0;
    xl_lat = 4'h0;
    for (int i = 0; i < 2; i++) begin
      flags = (i == 0) ? 4'h8 : 4'h4;
      n0 = n_req;
      pf_issue(32'h0000_3000, 16'h0000, 5'h00, ri_s, be_s);
      check("dropped", n_req - n0, 8'h00);
    end
    flags = 4'h0;
  endtask : t_attr
  task automatic t_barrier;
    int k = 0;
    stall = 4'h6;
    pf_take(32'h0000_4000, 16'h0000, 5'h00);
    barrier_req = 1'h1;
    while (pf_done !== 1'h1 && k++ < 60) begin
      check("early ack", barrier_ack, 1'h0);
      @(negedge clk_sys);
    end
    check("done before ack", pf_done, 1'h1);
    k = 0;
    while (barrier_ack !== 1'h1) begin
      if (++k > 8) begin
        check("ack wait", 32'h0, 32'h1);
        tally_and_finish();
      end
      @(negedge clk_sys);
    end
    check("ready at ack", pf_ready, 1'h0);
    barrier_req = 1'h0;
    stall = 4'h0;
  endtask : t_barrier
  initial begin
    repeat (4) @(negedge clk_sys);
    check("ready in reset", pf_ready, 1'h0);
    sys_rst = 1'h0;
    t_hints();
    t_addr();
    t_attr();
    t_barrier();
    check("gpr write", general_register_write_en, 1'h0);
    tally_and_finish();
  end
endmodule : test_prefetch_hint_unit
bind prefetch_hint_unit phu_checker #(.REPORT_ERRORS(REPORT_ERRORS)) u_chk (.clk_sys, .sys_rst,
  .release_new, .pf_valid, .pf_instr, .pf_ready, .pf_done, .pf_reserved_instr_exception,
  .pf_bus_error_exception, .general_register_write_en, .barrier_req, .barrier_ack, .xlt_valid,
  .xlt_vaddr, .xlt_rsp_valid, .xlt_rsp, .cache_req_valid, .cache_req, .cache_req_ready,
  .cache_done, .cache_error);
`default_nettype wire

/* File: hdl/phu_addr_gen.sv */
// Effective address adder for the prefetch unit.
// Assumes the offset arrives as the raw 16-bit instruction field.
`timescale 1ns/10ps
`default_nettype none

module phu_addr_gen (
  input  wire logic [phu_pkg::ADDR_W-1:0]   base,
  input  wire logic [phu_pkg::OFFSET_W-1:0] offset,
  input  wire logic                         release_new,
  output logic      [phu_pkg::ADDR_W-1:0]   vaddr
);
  import phu_pkg::*;

  // ----------------------------------------------------------------
  // Sign extension
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] sext(input logic [OFFSET_W-1:0] f,
                                             input logic rel_new);
    logic [ADDR_W-1:0] r;
    r = rel_new ? {{(ADDR_W-OFF_MSB_NEW-1){f[OFF_MSB_NEW]}}, f[OFF_MSB_NEW:0]}
                : {{(ADDR_W-OFF_MSB_OLD-1){f[OFF_MSB_OLD]}}, f};
    return r;
  endfunction : sext

  // Wraps modulo the address width, as the adder in the load path does
  assign vaddr = base + sext(offset, release_new);

endmodule : phu_addr_gen

`default_nettype wire

/* File: hdl/phu_hint_decode.sv */
// Combinational decode of the five-bit prefetch hint into an action.
// Assumes the release select is a steady configuration level.
`timescale 1ns/10ps
`default_nettype none

module phu_hint_decode #(
  parameter bit LRU_L1_SUPPORT = 1'b1
) (
  input  wire logic [phu_pkg::HINT_W-1:0] hint,
  input  wire logic                       release_new,
  output phu_pkg::phu_decode_t            dec
);
  import phu_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic phu_decode_t decode_hint(input logic [HINT_W-1:0] h,
                                              input logic rel_new);
    phu_decode_t d;
    logic [1:0]  grp;
    logic [2:0]  sub;
    d   = '{op: PHU_OP_NONE, level: PHU_LVL_L1, streamed: 1'b0,
            retained: 1'b0, reserved_instr: 1'b0};
    grp = h[HINT_W-1:HINT_GROUP_LO];
    sub = h[HINT_GROUP_LO-1:0];
    if (rel_new && h >= HINT_RSV_LO) begin
      d.reserved_instr = 1'b1;
    end else if (rel_new || grp == GROUP_L1) begin
      d.level = (grp == GROUP_L2) ? PHU_LVL_L2 :
                (grp == GROUP_L3) ? PHU_LVL_L3 : PHU_LVL_L1;
      unique case (sub)
        3'h0: d.op = PHU_OP_LOAD;
        3'h1: d.op = PHU_OP_STORE;
        3'h2: d.op = (rel_new && grp == GROUP_L1 && LRU_L1_SUPPORT)
                     ? PHU_OP_LRU : PHU_OP_NONE;
        3'h3: d.op = PHU_OP_NONE;
        3'h4, 3'h5, 3'h6, 3'h7: begin
          d.op       = sub[0] ? PHU_OP_STORE : PHU_OP_LOAD;
          d.streamed = ~sub[1];
          d.retained = sub[1];
        end
      endcase
      // Older releases reserve 2 and 3; doing nothing is always legal
      if (!rel_new && sub[2:1] == 2'h1) begin
        d.op = PHU_OP_NONE;
      end
    end
    return d;
  endfunction : decode_hint

  assign dec = decode_hint(hint, release_new);

endmodule : phu_hint_decode

`default_nettype wire

/* File: hdl/phu_pkg.sv */
// Package for the data prefetch unit: field widths, hint codes, states
// and the structs that carry requests between pipeline, translation and cache.
// Assumes a single core clock domain and a 32-bit effective address.

package phu_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 32;
  localparam int HINT_W        = 5;
  localparam int OFFSET_W      = 16;
  localparam int OFF_MSB_NEW   = 8;
  localparam int OFF_MSB_OLD   = 15;
  localparam int CCA_W         = 3;
  localparam int LEVEL_W       = 2;
  localparam int HINT_GROUP_LO = 3;

  // ----------------------------------------------------------------
  // Hint codes
  // ----------------------------------------------------------------
  localparam logic [HINT_W-1:0] HINT_LRU_L1   = 5'h02;
  localparam logic [HINT_W-1:0] HINT_IMPL_L1  = 5'h03;
  localparam logic [HINT_W-1:0] HINT_RSV_LO   = 5'h18;
  localparam logic [1:0]        GROUP_L1      = 2'h0;
  localparam logic [1:0]        GROUP_L2      = 2'h1;
  localparam logic [1:0]        GROUP_L3      = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PHU_OP_NONE  = 2'b00,
    PHU_OP_LOAD  = 2'b01,
    PHU_OP_STORE = 2'b10,
    PHU_OP_LRU   = 2'b11
  } phu_op_t;

  typedef enum logic [1:0] {
    PHU_LVL_L1 = 2'b00,
    PHU_LVL_L2 = 2'b01,
    PHU_LVL_L3 = 2'b10
  } phu_level_t;

  typedef enum logic [2:0] {
    PHU_ST_IDLE   = 3'b000,
    PHU_ST_XLATE  = 3'b001,
    PHU_ST_WAITXL = 3'b010,
    PHU_ST_ISSUE  = 3'b011,
    PHU_ST_WAITC  = 3'b100,
    PHU_ST_DONE   = 3'b101
  } phu_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   base;
    logic [OFFSET_W-1:0] offset;
    logic [HINT_W-1:0]   hint;
  } phu_instr_t;

  typedef struct packed {
    phu_op_t    op;
    phu_level_t level;
    logic       streamed;
    logic       retained;
    logic       reserved_instr;
  } phu_decode_t;

  typedef struct packed {
    logic              fault;
    logic              uncached;
    logic              coherent;
    logic [CCA_W-1:0]  cache_coherency_attribute;
    logic [ADDR_W-1:0] paddr;
  } phu_xlate_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic [CCA_W-1:0]  cache_coherency_attribute;
    logic              coherent;
    phu_op_t           op;
    phu_level_t        level;
    logic              streamed;
    logic              retained;
    logic              spare_locked;
  } phu_cache_req_t;

endpackage : phu_pkg

/* File: hdl/prefetch_hint_unit.sv */
// Top of the data prefetch unit: takes one prefetch from the pipeline,
// translates it, and issues at most one non-binding request to the caches.
// Assumes translation answers some cycles after its request and the
// cache answers every accepted request with one done pulse.
`timescale 1ns/10ps
`default_nettype none

module prefetch_hint_unit #(
  parameter bit REPORT_ERRORS  = 1'b0,
  parameter bit LRU_L1_SUPPORT = 1'b1
) (
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      release_new,
  // Pipeline side
  input  wire logic                      pf_valid,
  input  wire phu_pkg::phu_instr_t       pf_instr,
  output logic                           pf_ready,
  output logic                           pf_done,
  output logic                           pf_reserved_instr_exception,
  output logic                           pf_bus_error_exception,
  output logic                           general_register_write_en,
  // Barrier side
  input  wire logic                      barrier_req,
  output logic                           barrier_ack,
  // Translation side
  output logic                           xlt_valid,
  output logic [phu_pkg::ADDR_W-1:0]     xlt_vaddr,
  input  wire logic                      xlt_rsp_valid,
  input  wire phu_pkg::phu_xlate_t       xlt_rsp,
  // Cache side
  output logic                           cache_req_valid,
  output phu_pkg::phu_cache_req_t        cache_req,
  input  wire logic                      cache_req_ready,
  input  wire logic                      cache_done,
  input  wire logic                      cache_error
);
  import phu_pkg::*;

  // ----------------------------------------------------------------
  // Decode and address
  // ----------------------------------------------------------------
  phu_decode_t       dec_now;
  logic [ADDR_W-1:0] vaddr_now;

  phu_hint_decode #(
    .LRU_L1_SUPPORT (LRU_L1_SUPPORT)
  ) u_decode (
    .hint           (pf_instr.hint),
    .release_new    (release_new),
    .dec            (dec_now)
  );

  phu_addr_gen u_addr (
    .base           (pf_instr.base),
    .offset         (pf_instr.offset),
    .release_new    (release_new),
    .vaddr          (vaddr_now)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phu_state_t        state;
  phu_state_t        next_state;
  phu_decode_t       dec;
  phu_decode_t       next_dec;
  logic              take;

  logic                      next_pf_ready;
  logic                      next_pf_done;
  logic                      next_pf_ri;
  logic                      next_pf_be;
  logic                      next_barrier_ack;
  logic                      next_xlt_valid;
  logic [ADDR_W-1:0]         next_xlt_vaddr;
  logic                      next_cache_req_valid;
  phu_cache_req_t            next_cache_req;

  // A barrier loses to a prefetch offered in idle and is acked only once the one in flight has
  // drained, so no refill or writeback can pass the barrier.
  assign take = pf_valid && pf_ready;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_dec             = dec;
    next_pf_ready        = pf_ready;
    next_pf_done         = 1'b0;
    next_pf_ri           = 1'b0;
    next_pf_be           = 1'b0;
    next_barrier_ack     = 1'b0;
    next_xlt_valid       = 1'b0;
    next_xlt_vaddr       = xlt_vaddr;
    next_cache_req_valid = cache_req_valid;
    next_cache_req       = cache_req;
    unique case (state)
      PHU_ST_IDLE: begin
        if (take) begin
          next_pf_ready  = 1'b0;
          next_dec       = dec_now;
          next_xlt_vaddr = vaddr_now;
          if (dec_now.reserved_instr) begin
            next_state   = PHU_ST_DONE;
            next_pf_ri   = 1'b1;
            next_pf_done = 1'b1;
          end else if (dec_now.op == PHU_OP_NONE) begin
            next_state   = PHU_ST_DONE;
            next_pf_done = 1'b1;
          end else begin
            next_state     = PHU_ST_WAITXL;
            next_xlt_valid = 1'b1;
          end
        end else if (barrier_req) begin
          // Nothing in flight here, so the barrier completes at once
          next_pf_ready    = 1'b0;
          next_barrier_ack = 1'b1;
          next_state       = PHU_ST_DONE;
        end else begin
          next_pf_ready = 1'b1;
        end
      end
      PHU_ST_XLATE: begin
        next_state     = PHU_ST_WAITXL;
        next_xlt_valid = 1'b1;
      end
      PHU_ST_WAITXL: begin
        if (xlt_rsp_valid) begin
          if (xlt_rsp.fault || xlt_rsp.uncached) begin
            // Fault is dropped silently; uncached gets no traffic
            next_state   = PHU_ST_DONE;
            next_pf_done = 1'b1;
          end else begin
            next_cache_req.paddr    = xlt_rsp.paddr;
            next_cache_req.cache_coherency_attribute =
              xlt_rsp.cache_coherency_attribute;
            next_cache_req.coherent = xlt_rsp.coherent;
            next_cache_req.op       = dec.op;
            next_cache_req.level    = dec.level;
            next_cache_req.streamed = dec.streamed;
            next_cache_req.retained = dec.retained;
            next_cache_req.spare_locked = 1'b1;
            next_cache_req_valid    = 1'b1;
            next_state              = PHU_ST_ISSUE;
          end
        end
      end
      PHU_ST_ISSUE: begin
        if (cache_req_ready) begin
          next_cache_req_valid = 1'b0;
          next_state           = PHU_ST_WAITC;
        end
      end
      PHU_ST_WAITC: begin
        // Done covers refill and any victim writeback the cache chose
        if (cache_done) begin
          next_state   = PHU_ST_DONE;
          next_pf_done = 1'b1;
          next_pf_be   = REPORT_ERRORS && cache_error;
        end
      end
      PHU_ST_DONE: begin
        // One idle cycle keeps done and the next accept apart
        next_state    = PHU_ST_IDLE;
        next_pf_ready = 1'b1;
      end
      default: begin
        next_state    = PHU_ST_IDLE;
        next_pf_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state                       <= PHU_ST_IDLE;
      dec                         <= '{op: PHU_OP_NONE, level: PHU_LVL_L1,
                                       streamed: 1'b0, retained: 1'b0,
                                       reserved_instr: 1'b0};
      pf_ready                    <= 1'b0;
      pf_done                     <= 1'b0;
      pf_reserved_instr_exception <= 1'b0;
      pf_bus_error_exception      <= 1'b0;
      barrier_ack                 <= 1'b0;
      xlt_valid                   <= 1'b0;
      xlt_vaddr                   <= '0;
      cache_req_valid             <= 1'b0;
      cache_req                   <= '0;
    end else begin
      state                       <= next_state;
      dec                         <= next_dec;
      pf_ready                    <= next_pf_ready;
      pf_done                     <= next_pf_done;
      pf_reserved_instr_exception <= next_pf_ri;
      pf_bus_error_exception      <= next_pf_be;
      barrier_ack                 <= next_barrier_ack;
      xlt_valid                   <= next_xlt_valid;
      xlt_vaddr                   <= next_xlt_vaddr;
      cache_req_valid             <= next_cache_req_valid;
      cache_req                   <= next_cache_req;
    end
  end

  // ----------------------------------------------------------------
  // Register file port
  // ----------------------------------------------------------------
  // Kept as a flop so the pipeline sees a defined zero from reset
  logic next_gr_we;

  always_comb begin
    next_gr_we = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      general_register_write_en <= 1'b0;
    end else begin
      general_register_write_en <= next_gr_we;
    end
  end

endmodule : prefetch_hint_unit

`default_nettype wire
